// [vfds_consts.vh]
// Constants for the fault discharge sequencer
`ifndef VFDS_CONSTS_VH
`define VFDS_CONSTS_VH
`define VFDS_CLK_MHZ          250
`define VFDS_HRD_DLY_US       30000
`define VFDS_HRD_DLY_CYC      (`VFDS_HRD_DLY_US * `VFDS_CLK_MHZ)
`define VFDS_CBL_DLY_NS       16000
`define VFDS_CBL_DLY_CYC      ((`VFDS_CBL_DLY_NS * `VFDS_CLK_MHZ) / 1000)
`define VFDS_DISCHARGE_PIN_TMO_US      650000
`define VFDS_DISCHARGE_PIN_TMO_CYC     (`VFDS_DISCHARGE_PIN_TMO_US * `VFDS_CLK_MHZ)
`define VFDS_RESRC_US         765000
`define VFDS_RESRC_CYC        (`VFDS_RESRC_US * `VFDS_CLK_MHZ)
`define VFDS_CNT_W            28
`define VFDS_VSET_5V          2'b00
`define VFDS_ADV_5            3'b001
`define VFDS_ADV_5_12         3'b011
`define VFDS_ADV_5_20         3'b101
`define VFDS_ADV_5_12_20      3'b111
`endif

// [vfds_timer.v]
// Down-counting delay timer for the sequencer
`timescale 1ns/1ps
`default_nettype none
module vfds_timer #(
	parameter W = 28
) (
	input  wire         clk_sys_i,  // Core clock
	input  wire         resetn_i,   // Async reset, low
	input  wire         load_i,     // Load count
	input  wire [W-1:0] count_i,    // Cycles to run
	input  wire         stop_i,     // Abandon count
	output reg          done_o      // Pulse at expiry
);
	reg [W-1:0] cnt_q;
	reg         run_q;
	always @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cnt_q  <= {W{1'b0}};
			run_q  <= 1'b0;
			done_o <= 1'b0;
		end else begin
			done_o <= 1'b0;
			if (load_i) begin
				cnt_q <= count_i;
				run_q <= 1'b1;
			end else if (stop_i) begin
				run_q <= 1'b0;
			end else if (run_q) begin
				if (cnt_q <= {{(W-1){1'b0}}, 1'b1}) begin
					run_q  <= 1'b0;
					done_o <= 1'b1;
				end else begin
					cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
				end
			end
		end
	end
endmodule
`default_nettype wire

// [vfds_sequencer.v]
// VBUS fault discharge sequencer
`timescale 1ns/1ps
`default_nettype none
`include "vfds_consts.vh"
module vfds_sequencer #(
	parameter HRD_DLY_CYC  = `VFDS_HRD_DLY_CYC,
	parameter DISCHARGE_PIN_TMO_CYC = `VFDS_DISCHARGE_PIN_TMO_CYC,
	parameter RESRC_CYC    = `VFDS_RESRC_CYC,
	parameter CBL_DLY_CYC  = `VFDS_CBL_DLY_CYC
) (
	input  wire       clk_sys_i,                 // Core clock
	input  wire       resetn_i,                  // Async reset, low
	input  wire       attach_i,                  // Sink attached level
	input  wire       contract_done_i,           // Contract finalized level
	input  wire       source_req_i,              // Request to source VBUS
	input  wire       supply_sense_ok_i,         // Supply sense in range
	input  wire       vbus_below_sovp_i,         // VBUS below slow OV threshold
	input  wire       vbus_below_safe_i,         // VBUS below 0.725 V
	input  wire       supply_above_fovp_i,       // Supply sense above fast OV
	input  wire       hard_reset_rx_i,           // Hard reset received pulse
	input  wire       cable_removed_i,           // Cable unplug pulse
	input  wire       slow_fault_hr_i,           // Slow fault needing hard reset
	input  wire       fast_ovp_i,                // Fast overvoltage level
	input  wire       ocp_i,                     // Overcurrent level
	input  wire       first_msg_sent_i,          // First PD message sent
	input  wire       vbus_below_fth_i,          // VBUS below falling threshold
	input  wire       gate_override_input_i,     // Gate override pin
	input  wire       thermal_shutdown_i,        // Above first thermal limit
	input  wire       high_mid_voltage_enable_i, // Mid voltage enable pin
	input  wire       current_limit_select_i,    // Limit select level
	input  wire       select_resistor_i,         // Limit tied via resistor
	input  wire       power_halving_input_i,     // Power halving pin
	input  wire       caps_send_req_i,           // Capabilities about to be sent
	output reg        discharge_pin_weak_o,      // Bleed pulldown on
	output reg        discharge_pin_strong_o,    // Full discharge on
	output reg        supply_bleed_current_o,    // Draw bleed on supply sense
	output reg        nfet_gate_drive_o,         // NFET gate drive
	output reg        supply_select_a_o,         // Supply select bit A
	output reg        supply_select_b_o,         // Supply select bit B
	output reg        hard_reset_tx_o,           // Transmit hard reset pulse
	output reg        ovp_event_o,               // Overvoltage event pulse
	output reg        caps_retx_o,               // Retransmit capabilities pulse
	output reg  [2:0] adv_volt_o,                // Advertised set: bit0 5V,1 12V,2 20V
	output reg        current_limit_3a_o,        // Latched current limit select
	output reg        fault_busy_o               // Fault sequence active
);
	localparam [2:0] ST_IDLE   = 3'd0;
	localparam [2:0] ST_ON     = 3'd1;
	localparam [2:0] ST_SDLY   = 3'd2;
	localparam [2:0] ST_DSCG1  = 3'd3;
	localparam [2:0] ST_DSCG2  = 3'd4;
	localparam [2:0] ST_FAST   = 3'd5;
	localparam [2:0] ST_RESRC  = 3'd6;
	localparam       CW        = `VFDS_CNT_W;
	localparam [1:0] VSET_5V   = `VFDS_VSET_5V;

	reg  [2:0]    st_q;
	reg  [2:0]    st_d;
	reg           gd_prev_q;
	reg           ph_prev_q;
	reg           strap_done_q;
	reg           ilim_q;
	reg           resistor_q;
	reg  [CW-1:0] fast_cnt_q;
	reg  [CW-1:0] fast_lim_q;
	reg  [CW-1:0] phase_cnt_q;
	reg           hr_d;
	reg           ovp_d;
	reg           t_load;
	reg  [CW-1:0] t_count;
	reg           t_stop;
	wire          t_done;
	wire          gd_fall;
	wire          fast_fault;
	wire          slow_hr;
	wire          slow_any;
	wire          tmo_hit;

	vfds_timer #(
		.W(CW)
	) u_timer (
		.clk_sys_i(clk_sys_i),
		.resetn_i (resetn_i),
		.load_i   (t_load),
		.count_i  (t_count),
		.stop_i   (t_stop),
		.done_o   (t_done)
	);

	assign gd_fall    = gd_prev_q & ~gate_override_input_i;
	assign fast_fault = fast_ovp_i | (ocp_i & first_msg_sent_i) | vbus_below_fth_i
		| gd_fall;
	assign slow_hr    = slow_fault_hr_i;
	assign slow_any   = slow_hr | hard_reset_rx_i | cable_removed_i;
	// Discharge timeout counted on the phase timer, apart from the delay timer
	assign tmo_hit    = (phase_cnt_q >= DISCHARGE_PIN_TMO_CYC[CW-1:0]);

	always @* begin
		st_d    = st_q;
		hr_d    = 1'b0;
		ovp_d   = 1'b0;
		t_load  = 1'b0;
		t_count = {CW{1'b0}};
		t_stop  = 1'b0;
		case (st_q)
			ST_IDLE: begin
				if (attach_i && source_req_i && supply_sense_ok_i) begin
					st_d = ST_ON;
				end
			end
			ST_ON: begin
				if (fast_fault) begin
					st_d  = ST_FAST;
					hr_d  = 1'b1;
				end else if (slow_any) begin
					st_d   = ST_SDLY;
					t_load = 1'b1;
					hr_d   = slow_hr;
					t_count = cable_removed_i ? CBL_DLY_CYC[CW-1:0]
						: HRD_DLY_CYC[CW-1:0];
				end else if (!attach_i) begin
					st_d = ST_IDLE;
				end
			end
			ST_SDLY: begin
				if (fast_fault) begin
					st_d = ST_FAST;
					hr_d = 1'b1;
				end else if (t_done) begin
					st_d = ST_DSCG1;
				end
			end
			ST_DSCG1: begin
				if (fast_fault) begin
					st_d = ST_FAST;
					hr_d = 1'b1;
				end else if (tmo_hit) begin
					st_d = ST_DSCG1;
					hr_d = 1'b1;
				end else if (vbus_below_sovp_i) begin
					st_d = ST_DSCG2;
				end
			end
			ST_DSCG2: begin
				if (tmo_hit) begin
					st_d = ST_DSCG1;
					hr_d = 1'b1;
				end else if (vbus_below_safe_i) begin
					st_d    = ST_RESRC;
					t_load  = 1'b1;
					t_count = RESRC_CYC[CW-1:0];
				end
			end
			ST_FAST: begin
				if (!supply_above_fovp_i && vbus_below_safe_i) begin
					st_d    = ST_RESRC;
					t_load  = 1'b1;
					t_count = RESRC_CYC[CW-1:0];
				end else if (fast_cnt_q >= fast_lim_q) begin
					ovp_d = 1'b1;
					hr_d  = 1'b1;
				end
			end
			ST_RESRC: begin
				if (t_done) begin
					st_d = ST_IDLE;
				end
			end
			default: begin
				st_d   = ST_IDLE;
				t_stop = 1'b1;
			end
		endcase
	end

	always @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			st_q                   <= ST_IDLE;
			gd_prev_q              <= 1'b1;
			ph_prev_q              <= 1'b0;
			strap_done_q           <= 1'b0;
			ilim_q                 <= 1'b0;
			resistor_q             <= 1'b0;
			fast_cnt_q             <= {CW{1'b0}};
			fast_lim_q             <= {CW{1'b0}};
			phase_cnt_q            <= {CW{1'b0}};
			discharge_pin_weak_o   <= 1'b0;
			discharge_pin_strong_o <= 1'b0;
			supply_bleed_current_o <= 1'b0;
			nfet_gate_drive_o      <= 1'b0;
			supply_select_a_o      <= 1'b0;
			supply_select_b_o      <= 1'b0;
			hard_reset_tx_o        <= 1'b0;
			ovp_event_o            <= 1'b0;
			caps_retx_o            <= 1'b0;
			adv_volt_o             <= `VFDS_ADV_5;
			current_limit_3a_o     <= 1'b0;
			fault_busy_o           <= 1'b0;
		end else begin
			st_q            <= st_d;
			gd_prev_q       <= gate_override_input_i;
			ph_prev_q       <= power_halving_input_i;
			hard_reset_tx_o <= hr_d;
			ovp_event_o     <= ovp_d;
			// Strap capture once after reset release
			if (!strap_done_q) begin
				strap_done_q <= 1'b1;
				ilim_q       <= current_limit_select_i;
				resistor_q   <= select_resistor_i;
			end
			current_limit_3a_o <= ilim_q;
			caps_retx_o <= strap_done_q & (ph_prev_q ^ power_halving_input_i);
			// Mid-voltage pin looked at only when capabilities go out
			if (caps_send_req_i && strap_done_q) begin
				case ({high_mid_voltage_enable_i, resistor_q})
					2'b10:   adv_volt_o <= `VFDS_ADV_5_12_20;
					2'b11:   adv_volt_o <= `VFDS_ADV_5_12;
					2'b00:   adv_volt_o <= `VFDS_ADV_5_20;
					default: adv_volt_o <= `VFDS_ADV_5;
				endcase
			end
			// Phase timer restarts on entry to discharge or on retry
			if ((st_d == ST_DSCG1 && (st_q != ST_DSCG1 || hr_d))) begin
				phase_cnt_q <= {CW{1'b0}};
			end else if (st_q == ST_DSCG1 || st_q == ST_DSCG2) begin
				phase_cnt_q <= phase_cnt_q + {{(CW-1){1'b0}}, 1'b1};
			end
			if (st_q != ST_FAST && st_d == ST_FAST) begin
				fast_cnt_q <= {CW{1'b0}};
				fast_lim_q <= (phase_cnt_q + RESRC_CYC[CW-1:0]);
			end else if (st_q == ST_FAST) begin
				if (ovp_d) begin
					fast_cnt_q <= {CW{1'b0}};
				end else if (supply_above_fovp_i) begin
					fast_cnt_q <= fast_cnt_q + {{(CW-1){1'b0}}, 1'b1};
				end
			end
			if (st_q == ST_DSCG2 && st_d == ST_RESRC) begin
				fast_lim_q <= phase_cnt_q; // Last discharge intervals
			end
			nfet_gate_drive_o <= (st_d == ST_ON) || (st_d == ST_SDLY)
				|| (st_d == ST_DSCG1);
			discharge_pin_strong_o <= ((st_d == ST_DSCG1) || (st_d == ST_DSCG2)
				|| (st_d == ST_FAST)) && !thermal_shutdown_i;
			discharge_pin_weak_o <= ((attach_i && !contract_done_i) || (st_d == ST_SDLY)
				|| (st_d == ST_DSCG1) || (st_d == ST_DSCG2) || (st_d == ST_FAST))
				&& !thermal_shutdown_i;
			supply_bleed_current_o <= (attach_i && !contract_done_i) || (st_d == ST_SDLY)
				|| (st_d == ST_DSCG1) || (st_d == ST_DSCG2)
				|| (st_d == ST_FAST);
			if (st_d == ST_DSCG1 || st_d == ST_FAST) begin
				supply_select_a_o <= VSET_5V[1];
				supply_select_b_o <= VSET_5V[0];
			end
			fault_busy_o <= (st_d != ST_IDLE) && (st_d != ST_ON);
		end
	end
endmodule
`default_nettype wire

// [vfds_vbus_model.sv]
// VBUS level model facing the sequencer outputs
`timescale 1ns/1ps
`default_nettype none
module vfds_vbus_model (
	input  wire logic clk_sys_i,    // Clock
	input  wire logic gate_i,       // Gate drive
	input  wire logic strong_i,     // Full discharge
	input  wire logic stall_i,      // Stuck above safe
	output wire logic below_sovp_o, // Below slow OV
	output wire logic below_safe_o  // Below 0.725 V
);
	logic [4:0] lvl_q = 5'd31;
	always @(posedge clk_sys_i) begin
		if (gate_i && !strong_i)
			lvl_q <= 5'd0;
		else if (strong_i && lvl_q != 5'd31 && !(stall_i && lvl_q == 5'd15))
			lvl_q <= lvl_q + 5'd1;
	end
	assign below_sovp_o = lvl_q >= 5'd8;
	assign below_safe_o = lvl_q >= 5'd16;
endmodule
`default_nettype wire

// [vfds_seq_assertions.sv]
// Port checker for the fault discharge sequencer
`timescale 1ns/1ps
`default_nettype none
module vfds_seq_assertions (
	input wire logic       clk_sys_i,                 // Clock
	input wire logic       resetn_i,                  // Reset
	input wire logic       attach_i,                  // Attach
	input wire logic       contract_done_i,           // Contract
	input wire logic       supply_sense_ok_i,         // Sense ok
	input wire logic       hard_reset_rx_i,           // HR in
	input wire logic       slow_fault_hr_i,           // Slow fault
	input wire logic       fast_ovp_i,                // Fast OV
	input wire logic       thermal_shutdown_i,        // Thermal
	input wire logic       high_mid_voltage_enable_i, // Mid enable
	input wire logic       select_resistor_i,         // Strap
	input wire logic       power_halving_input_i,     // Halving
	input wire logic       caps_send_req_i,           // Caps send
	input wire logic       discharge_pin_weak_o,      // Bleed
	input wire logic       discharge_pin_strong_o,    // Full
	input wire logic       supply_bleed_current_o,    // Supply bleed
	input wire logic       nfet_gate_drive_o,         // Gate
	input wire logic       supply_select_a_o,         // Select A
	input wire logic       supply_select_b_o,         // Select B
	input wire logic       hard_reset_tx_o,           // HR out
	input wire logic       caps_retx_o,               // Caps retx
	input wire logic [2:0] adv_volt_o,                // Advertised
	input wire logic       current_limit_3a_o,        // Limit
	input wire logic       fault_busy_o               // Busy
);
	logic [1:0] age_q;
	always @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i)
			age_q <= 2'd0;
		else if (age_q != 2'd3)
			age_q <= age_q + 2'd1;
	end
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!resetn_i);
	property p_fast; $rose(fast_ovp_i) && nfet_gate_drive_o |=> !nfet_gate_drive_o && hard_reset_tx_o; endproperty
	a_fast: assert property (p_fast) else $error("fast fault handling");
	property p_rx; hard_reset_rx_i && nfet_gate_drive_o && !fault_busy_o && !fast_ovp_i |=> !hard_reset_tx_o && nfet_gate_drive_o && supply_bleed_current_o; endproperty
	a_rx: assert property (p_rx) else $error("received reset handling");
	property p_hr; slow_fault_hr_i && nfet_gate_drive_o && !fault_busy_o |=> hard_reset_tx_o; endproperty
	a_hr: assert property (p_hr) else $error("hard reset not at start");
	property p_sel; $rose(discharge_pin_strong_o) && nfet_gate_drive_o |-> !supply_select_a_o && !supply_select_b_o; endproperty
	a_sel: assert property (p_sel) else $error("select not 5V");
	property p_gate; $rose(nfet_gate_drive_o) |-> $past(supply_sense_ok_i); endproperty
	a_gate: assert property (p_gate) else $error("gate without sense");
	property p_bleed; age_q == 2'd3 && attach_i && !contract_done_i && !thermal_shutdown_i |=> discharge_pin_weak_o && supply_bleed_current_o; endproperty
	a_bleed: assert property (p_bleed) else $error("bleed missing");
	property p_therm; thermal_shutdown_i |=> !discharge_pin_weak_o && !discharge_pin_strong_o; endproperty
	a_therm: assert property (p_therm) else $error("pulldown in thermal");
	property p_latch; age_q == 2'd3 |-> $stable(current_limit_3a_o); endproperty
	a_latch: assert property (p_latch) else $error("limit moved");
	property p_halve; age_q == 2'd3 && $changed(power_halving_input_i) |-> ##[1:3] caps_retx_o; endproperty
	a_halve: assert property (p_halve) else $error("no caps retx");
	property p_adv; caps_send_req_i |=> adv_volt_o == {!$past(select_resistor_i), $past(high_mid_voltage_enable_i), 1'b1}; endproperty
	a_adv: assert property (p_adv) else $error("advertised set");
	c_hr: cover property (hard_reset_tx_o && !nfet_gate_drive_o);
	c_caps: cover property (caps_retx_o);
	c_done: cover property ($fell(fault_busy_o));
endmodule
bind vfds_sequencer vfds_seq_assertions u_chk (.*);
`default_nettype wire

// [tb_vfds_sequencer.sv]
// Self-checking testbench for the fault discharge sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin n_mismatch++; $display("Error %0t got %h exp %h", $time, a, e); end end
`define WAITC(c, n) for (int k = 0; k < (n) && !(c); k++) @(posedge clk_sys_i);
module tb_vfds_sequencer;
	localparam HRD = 50, TMO = 200, RSC = 100, CBL = 10;
	logic clk_sys_i = 0, resetn_i = 0, attach_i = 0, contract_done_i = 0, source_req_i = 0;
	logic supply_sense_ok_i = 0, hard_reset_rx_i = 0, cable_removed_i = 0, slow_fault_hr_i = 0;
	logic fast_ovp_i = 0, ocp_i = 0, first_msg_sent_i = 1, vbus_below_fth_i = 0;
	logic gate_override_input_i = 1, thermal_shutdown_i = 0, high_mid_voltage_enable_i = 0;
	logic current_limit_select_i = 0, select_resistor_i = 0, power_halving_input_i = 0;
	logic caps_send_req_i = 0, supply_above_fovp_i = 0, stall = 0;
	wire vbus_below_sovp_i, vbus_below_safe_i, discharge_pin_weak_o, discharge_pin_strong_o;
	wire supply_bleed_current_o, nfet_gate_drive_o, supply_select_a_o, supply_select_b_o;
	wire hard_reset_tx_o, ovp_event_o, caps_retx_o, current_limit_3a_o, fault_busy_o;
	wire [2:0] adv_volt_o;
	int n_mismatch = 0, tests_run = 0, cyc = 0, n;
	logic [2:0] exp_q[$], exp_v;
	vfds_sequencer #(.HRD_DLY_CYC(HRD), .DISCHARGE_PIN_TMO_CYC(TMO), .RESRC_CYC(RSC), .CBL_DLY_CYC(CBL)) u_dut (.*);
	vfds_vbus_model u_vbus (.clk_sys_i(clk_sys_i), .gate_i(nfet_gate_drive_o),
		.strong_i(discharge_pin_strong_o), .stall_i(stall),
		.below_sovp_o(vbus_below_sovp_i), .below_safe_o(vbus_below_safe_i));
	initial forever #2 clk_sys_i = ~clk_sys_i;
	task automatic complete_run();
		$display("Comparisons %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic note(string s);
		$display("Test %s done", s);
	endtask
	// One-cycle strobe: 0 reset rx, 1 slow fault, 2 cable, 3 caps send
	task automatic pulse(input int w);
		case (w)
			0: hard_reset_rx_i <= 1;
			1: slow_fault_hr_i <= 1;
			2: cable_removed_i <= 1;
			default: caps_send_req_i <= 1;
		endcase
		@(posedge clk_sys_i);
		{hard_reset_rx_i, slow_fault_hr_i, cable_removed_i, caps_send_req_i} <= 4'b0000;
	endtask
	task automatic do_reset();
		resetn_i <= 0;
		current_limit_select_i <= 1'($urandom);
		select_resistor_i <= 1'($urandom);
		repeat (20) @(posedge clk_sys_i);
		`CHK({nfet_gate_drive_o, hard_reset_tx_o, adv_volt_o}, 5'b00001)
		resetn_i <= 1;
		repeat (3) @(posedge clk_sys_i);
		`CHK(current_limit_3a_o, current_limit_select_i)
		note("reset");
	endtask
	task automatic src_on();
		@(posedge clk_sys_i);
		`WAITC(!fault_busy_o, 400)
		attach_i <= 1;
		supply_sense_ok_i <= 0;
		source_req_i <= 1;
		repeat (4) @(posedge clk_sys_i);
		`CHK(nfet_gate_drive_o, 1'b0)
		supply_sense_ok_i <= 1;
		`WAITC(nfet_gate_drive_o, 10)
		`CHK({nfet_gate_drive_o, discharge_pin_weak_o, supply_bleed_current_o}, 3'b111)
	endtask
	// Each result pulse is matched against the oldest expectation
	always @(posedge clk_sys_i) begin
		cyc++;
		if (cyc == 6000) begin
			n_mismatch++;
			complete_run();
		end
		if (resetn_i && (hard_reset_tx_o || caps_retx_o || ovp_event_o)) begin
			exp_v = exp_q.size() ? exp_q.pop_front() : 3'b000;
			`CHK({ovp_event_o, caps_retx_o, hard_reset_tx_o}, exp_v)
		end
	end
	initial begin
		void'($urandom(32'h9686));
		do_reset();
		src_on();
		thermal_shutdown_i <= 1;
		repeat (2) @(posedge clk_sys_i);
		`CHK(discharge_pin_weak_o, 1'b0)
		{thermal_shutdown_i, contract_done_i} <= 2'b01;
		repeat (2) @(posedge clk_sys_i);
		`CHK({discharge_pin_weak_o, supply_bleed_current_o}, 2'b00)
		contract_done_i <= 0;
		pulse(0);
		repeat (HRD - 8) @(posedge clk_sys_i);
		`CHK({nfet_gate_drive_o, discharge_pin_strong_o}, 2'b10)
		`WAITC(discharge_pin_strong_o, 20)
		`CHK({discharge_pin_strong_o, supply_select_a_o, supply_select_b_o}, 3'b100)
		source_req_i <= 0;
		`WAITC(!nfet_gate_drive_o, 30)
		`CHK({vbus_below_sovp_i, discharge_pin_strong_o}, 2'b11)
		`WAITC(vbus_below_safe_i, 30)
		for (n = 0; n < 2 * RSC && fault_busy_o; n++) @(posedge clk_sys_i);
		`CHK(n >= RSC && n <= RSC + 6, 1'b1)
		note("slow");
		src_on();
		stall <= 1;
		exp_q.push_back(3'b001);
		exp_q.push_back(3'b001);
		pulse(1);
		repeat (HRD + TMO - 12) @(posedge clk_sys_i);
		`CHK(exp_q.size(), 1)
		repeat (20) @(posedge clk_sys_i);
		`CHK(exp_q.size(), 0)
		stall <= 0;
		source_req_i <= 0;
		note("timeout");
		for (int f = 0; f < 4; f++) begin
			src_on();
			if (f == 1) begin
				{first_msg_sent_i, ocp_i} <= 2'b01;
				repeat (2) @(posedge clk_sys_i);
				`CHK(nfet_gate_drive_o, 1'b1)
				first_msg_sent_i <= 1;
			end
			exp_q.push_back(3'b001);
			case (f)
				0: {fast_ovp_i, supply_above_fovp_i} <= 2'b11;
				1: ocp_i <= 1;
				2: vbus_below_fth_i <= 1;
				default: gate_override_input_i <= 0;
			endcase
			source_req_i <= 0;
			repeat (2) @(posedge clk_sys_i);
			`CHK({nfet_gate_drive_o, discharge_pin_strong_o, discharge_pin_weak_o, supply_bleed_current_o}, 4'b0111)
			// Supply stuck above fast OV: one repeat after the re-source wait
			if (f == 0) begin
				exp_q.push_back(3'b101);
				for (n = 0; n < 2 * TMO && !ovp_event_o; n++) @(posedge clk_sys_i);
				`CHK(n > RSC && n < RSC + TMO, 1'b1)
			end
			{fast_ovp_i, ocp_i, vbus_below_fth_i, gate_override_input_i} <= 4'b0001;
			supply_above_fovp_i <= 0;
		end
		note("fast");
		src_on();
		pulse(2);
		`WAITC(discharge_pin_strong_o, CBL + 6)
		`CHK(discharge_pin_strong_o, 1'b1)
		source_req_i <= 0;
		`WAITC(!fault_busy_o, 400)
		note("cable");
		exp_q.push_back(3'b010);
		power_halving_input_i <= 1;
		repeat (6) @(posedge clk_sys_i);
		high_mid_voltage_enable_i <= 1;
		repeat (6) @(posedge clk_sys_i);
		for (int i = 0; i < 6; i++) begin
			high_mid_voltage_enable_i <= 1'($urandom);
			@(posedge clk_sys_i);
			pulse(3);
			@(posedge clk_sys_i);
			`CHK(adv_volt_o, {~select_resistor_i, high_mid_voltage_enable_i, 1'b1})
		end
		`CHK(exp_q.size(), 0)
		note("caps");
		do_reset();
		complete_run();
	end
endmodule
`default_nettype wire
